// *** iafc_ctrl.sv ***
// Added by the designer: the placing of the registers and register access over APB.
`include "iafc_map.svh"
// Overview of operation
// - mode field decodes 000 write, 001 erase, 011 read, 110 unlock.
// - setting unlock trigger starts a timer; hardware clears it at expiry.
// - key bytes written during the timer window enable erase/write.
// - trigger bit clears at expiry whether keys matched or not.
// - wrong keys leave erase/write disabled; software retries whole sequence.
// - successful unlock sets the enable status bit in hardware.
// - write initiate stays high during the operation, clears on completion.
// - erase mode plus write initiate erases the addressed page.
// - reads happen only while read enable is high.
// - read initiate clears itself when the single-word read finishes.
// - cpu stalls from successful start until the operation ends.
// - writing 55h to the reset pattern register resets the chip.
// - buffer clear bit clears itself when the buffer clear finishes.
// - buffer holds 64 words of the page chosen by address bits 13:6.
// - high data byte write loads the word and bumps the address.
// - the address stops at the last word of the page.
// - erase or write takes 2.2 ms from initiate to clear.
// - software may clear enable status any time, no unlock needed.
// - an erased page reads all 0000h; software verifies and retries.
// - enable status ignores software ones; only unlock logic sets it.
// - a low data byte write only updates that register.
// - finished read places the word in data pair 0 in the same cycle the bit clears.
// - a read takes three instruction cycles until the bit clears.
module iafc_ctrl
  import iafc_pkg::*;
#(
  parameter int EW_CYC     = `IAFC_EW_CYC,
  parameter int READ_CYC   = `IAFC_READ_CYC,
  parameter int UNLOCK_CYC = `IAFC_UNLOCK_CYC,
  parameter int PAGE_WORDS = 64,
  parameter int TW         = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cpu_stall,
  output logic             chip_rst_req,
  output logic             flash_rd_req,
  output logic             flash_erase_req,
  output logic             flash_prog_req,
  output logic      [13:0] flash_addr,
  output logic      [15:0] flash_wdata,
  input  wire logic [15:0] flash_rdata
);

  localparam int PW = $clog2(PAGE_WORDS);

  if (PAGE_WORDS != 64 || EW_CYC < 2 * PAGE_WORDS + 8
      || EW_CYC >= 2 ** TW || READ_CYC < 1 || UNLOCK_CYC < 1
      || READ_CYC >= 2 ** TW || UNLOCK_CYC >= 2 ** TW) begin : g_chk
    $error("iafc_ctrl: unsupported parameter values");
  end

  iafc_state_t s_r;
  iafc_state_t s_nxt;

  logic          tmr_start;
  logic [TW-1:0] tmr_load;
  logic          tmr_expire;
  logic          buf_we;
  logic [PW-1:0] buf_waddr;
  logic [15:0]   buf_wdata;
  logic [15:0]   buf_rdata;

  iafc_timer #(.W(TW)) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (tmr_start),
    .load_val (tmr_load),
    .busy     (),
    .expire   (tmr_expire)
  );

  iafc_wbuf #(.DEPTH(PAGE_WORDS), .WIDTH(16)) u_wbuf (
    .core_clk (core_clk),
    .we       (buf_we),
    .waddr    (buf_waddr),
    .wdata    (buf_wdata),
    .raddr    (s_r.idx[PW-1:0]),
    .rdata    (buf_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////

  logic        setup;
  logic        commit;
  logic        wr;
  logic        idle;
  logic [7:0]  wb;
  logic        key_ok;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        all_three;

  always_comb begin
    s_nxt     = s_r;
    tmr_start = 1'b0;
    tmr_load  = '0;
    buf_we    = 1'b0;
    buf_waddr = s_r.addr[PW-1:0];
    buf_wdata = {s_r.d0h, s_r.d0l};
    setup     = psel && !penable;
    commit    = psel && penable && s_r.pready;
    wr        = commit && pwrite && !s_r.pslverr;
    idle      = (s_r.st == IAFC_IDLE);
    wb        = pwdata[7:0];
    key_ok    = (s_r.k1l == `IAFC_KEY1_LO) && (s_r.k2l == `IAFC_KEY2_LO)
             && (s_r.k3l == `IAFC_KEY3_LO) && (s_r.k1h == `IAFC_KEY1_HI)
             && (s_r.k2h == `IAFC_KEY2_HI) && (s_r.k3h == `IAFC_KEY3_HI);
    all_three = wb[`IAFC_BIT_WI] && wb[`IAFC_BIT_RDE] && wb[`IAFC_BIT_RI];

    // one-shot pulses default low
    s_nxt.chip_rst = 1'b0;
    s_nxt.read_initiate      = 1'b0;
    s_nxt.fera     = 1'b0;
    s_nxt.fprog    = 1'b0;

    // apb read path: data sampled at setup, answered in first access cycle
    mapped = 1'b1;
    rd_mux = '0;
    case (paddr)
      `IAFC_OFF_CTRL:    rd_mux[7:0] = {s_r.ew_en, s_r.mode, s_r.trig,
                                        s_r.wi, s_r.rde, s_r.ri};
      `IAFC_OFF_RSTPAT:  rd_mux[7:0] = s_r.rst_pat;
      `IAFC_OFF_BUFCLR:  rd_mux[`IAFC_BIT_CLR] = s_r.clr;
      `IAFC_OFF_ADDR_LO: rd_mux[7:0] = s_r.addr[7:0];
      `IAFC_OFF_ADDR_HI: rd_mux[5:0] = s_r.addr[13:8];
      `IAFC_OFF_D0_LO:   rd_mux[7:0] = s_r.d0l;
      `IAFC_OFF_D0_HI:   rd_mux[7:0] = s_r.d0h;
      `IAFC_OFF_K1_LO:   rd_mux[7:0] = s_r.k1l;
      `IAFC_OFF_K1_HI:   rd_mux[7:0] = s_r.k1h;
      `IAFC_OFF_K2_LO:   rd_mux[7:0] = s_r.k2l;
      `IAFC_OFF_K2_HI:   rd_mux[7:0] = s_r.k2h;
      `IAFC_OFF_K3_LO:   rd_mux[7:0] = s_r.k3l;
      `IAFC_OFF_K3_HI:   rd_mux[7:0] = s_r.k3h;
      default:           mapped = 1'b0;
    endcase
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && !mapped;
    if (setup) begin
      s_nxt.prdata = rd_mux;
    end

    //////////////////////////////////////////////////////////////////////////
    // register writes; hardware sequencing below overrides where it must

    if (wr) begin
      case (paddr)
        `IAFC_OFF_CTRL: begin
          if (!wb[`IAFC_BIT_EWEN]) begin
            s_nxt.ew_en = 1'b0;
          end
          if (idle) begin
            s_nxt.mode = wb[`IAFC_MODE_MSB:`IAFC_MODE_LSB];
            s_nxt.rde  = wb[`IAFC_BIT_RDE];
            // a write raising all three start/enable bits leaves both start bits unchanged
            if (!all_three) begin
              s_nxt.wi = wb[`IAFC_BIT_WI];
              s_nxt.ri = wb[`IAFC_BIT_RI];
            end
            if (wb[`IAFC_BIT_TRIG]) begin
              s_nxt.trig = 1'b1;
              s_nxt.st   = IAFC_UNLOCK;
              tmr_start  = 1'b1;
              tmr_load   = TW'(UNLOCK_CYC);
            end
          end
        end
        `IAFC_OFF_RSTPAT: begin
          s_nxt.rst_pat  = wb;
          s_nxt.chip_rst = (wb == `IAFC_RST_PATTERN);
        end
        `IAFC_OFF_BUFCLR: begin
          if (idle && wb[`IAFC_BIT_CLR]) begin
            s_nxt.clr        = 1'b1;
            s_nxt.idx        = '0;
            s_nxt.after_prog = 1'b0;
            s_nxt.st         = IAFC_BCLR;
          end
        end
        `IAFC_OFF_ADDR_LO: s_nxt.addr[7:0]  = wb;
        `IAFC_OFF_ADDR_HI: s_nxt.addr[13:8] = wb[5:0];
        `IAFC_OFF_D0_LO:   s_nxt.d0l = wb;
        `IAFC_OFF_D0_HI: begin
          s_nxt.d0h = wb;
          // buffer fill only once erase/write is unlocked
          if (idle && s_r.ew_en) begin
            buf_we    = 1'b1;
            buf_wdata = {wb, s_r.d0l};
            if (s_r.addr[PW-1:0] != '1) begin
              s_nxt.addr = s_r.addr + 14'h1;
            end
          end
        end
        `IAFC_OFF_K1_LO:   s_nxt.k1l = wb;
        `IAFC_OFF_K1_HI:   s_nxt.k1h = wb;
        `IAFC_OFF_K2_LO:   s_nxt.k2l = wb;
        `IAFC_OFF_K2_HI:   s_nxt.k2h = wb;
        `IAFC_OFF_K3_LO:   s_nxt.k3l = wb;
        `IAFC_OFF_K3_HI:   s_nxt.k3h = wb;
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // operation sequencer

    case (s_r.st)
      IAFC_IDLE: begin
        // start bits were latched last cycle; decide on them here
        if (s_r.wi) begin
          if (s_r.ew_en && s_r.mode == `IAFC_MODE_ERASE) begin
            s_nxt.fera  = 1'b1;
            s_nxt.faddr = {s_r.addr[13:PW], {PW{1'b0}}};
            s_nxt.stall = 1'b1;
            tmr_start   = 1'b1;
            tmr_load    = TW'(EW_CYC - 1);
            s_nxt.st    = IAFC_WAIT;
          end else if (s_r.ew_en && s_r.mode == `IAFC_MODE_WRITE) begin
            s_nxt.stall = 1'b1;
            s_nxt.idx   = '0;
            tmr_start   = 1'b1;
            tmr_load    = TW'(EW_CYC - 1);
            s_nxt.st    = IAFC_PROG;
          end else begin
            s_nxt.wi = 1'b0;
          end
        end else if (s_r.ri) begin
          if (s_r.rde && s_r.mode == `IAFC_MODE_READ) begin
            s_nxt.read_initiate   = 1'b1;
            s_nxt.faddr = s_r.addr;
            s_nxt.stall = 1'b1;
            tmr_start   = 1'b1;
            tmr_load    = TW'(READ_CYC - 1);
            s_nxt.st    = IAFC_READ;
          end else begin
            s_nxt.ri = 1'b0;
          end
        end
      end
      IAFC_UNLOCK: begin
        if (tmr_expire) begin
          s_nxt.trig = 1'b0;
          s_nxt.st   = IAFC_IDLE;
          // set wins over a software clear landing in this cycle
          if (key_ok && s_r.mode == `IAFC_MODE_UNLOCK) begin
            s_nxt.ew_en = 1'b1;
          end
        end
      end
      IAFC_PROG: begin
        // buffer read data lags the index by one cycle
        s_nxt.fprog  = (s_r.idx != '0);
        s_nxt.faddr  = {s_r.addr[13:PW], PW'(s_r.idx - 7'h1)};
        s_nxt.fwdata = buf_rdata;
        s_nxt.idx    = s_r.idx + 7'h1;
        if (s_r.idx == 7'(PAGE_WORDS)) begin
          s_nxt.idx        = '0;
          s_nxt.after_prog = 1'b1;
          s_nxt.st         = IAFC_BCLR;
        end
      end
      IAFC_BCLR: begin
        // one word per cycle; the clear costs a page of cycles
        buf_we    = 1'b1;
        buf_waddr = s_r.idx[PW-1:0];
        buf_wdata = '0;
        s_nxt.idx = s_r.idx + 7'h1;
        if (s_r.idx == 7'(PAGE_WORDS - 1)) begin
          s_nxt.idx = '0;
          if (s_r.after_prog) begin
            s_nxt.st = IAFC_WAIT;
          end else begin
            s_nxt.clr = 1'b0;
            s_nxt.st  = IAFC_IDLE;
          end
        end
      end
      IAFC_WAIT: begin
        if (tmr_expire) begin
          s_nxt.wi         = 1'b0;
          s_nxt.stall      = 1'b0;
          s_nxt.after_prog = 1'b0;
          s_nxt.st         = IAFC_IDLE;
        end
      end
      IAFC_READ: begin
        if (tmr_expire) begin
          s_nxt.d0l   = flash_rdata[7:0];
          s_nxt.d0h   = flash_rdata[15:8];
          s_nxt.ri    = 1'b0;
          s_nxt.stall = 1'b0;
          s_nxt.st    = IAFC_IDLE;
        end
      end
      default: begin
        s_nxt.st = IAFC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.st      <= IAFC_IDLE;
      s_r.rst_pat <= `IAFC_RESET_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata          = s_r.prdata;
  assign pready          = s_r.pready;
  assign pslverr         = s_r.pslverr;
  assign cpu_stall       = s_r.stall;
  assign chip_rst_req    = s_r.chip_rst;
  assign flash_rd_req    = s_r.read_initiate;
  assign flash_erase_req = s_r.fera;
  assign flash_prog_req  = s_r.fprog;
  assign flash_addr      = s_r.faddr;
  assign flash_wdata     = s_r.fwdata;

endmodule

// *** iafc_ctrl_assertions.sv ***
module iafc_ctrl_assertions #(
  parameter int EW_CYC   = 22000,
  parameter int READ_CYC = 12
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_stall,
  input wire logic        chip_rst_req,
  input wire logic        flash_rd_req,
  input wire logic        flash_erase_req,
  input wire logic        flash_prog_req,
  input wire logic [13:0] flash_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] len_r;
  logic [6:0]  prog_cnt_r;
  logic        was_rd_r;
  wire         wr_c = psel && penable && pready && pwrite;
  // stall length and pulse count of the operation in progress
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      len_r <= 16'h0;
      prog_cnt_r <= 7'h0;
      was_rd_r <= 1'b0;
    end else begin
      len_r <= cpu_stall ? len_r + 16'h1 : 16'h0;
      if (flash_prog_req)
        prog_cnt_r <= prog_cnt_r + 7'h1;
      else if (!cpu_stall)
        prog_cnt_r <= 7'h0;
      if (flash_rd_req)
        was_rd_r <= 1'b1;
      else if (flash_erase_req || flash_prog_req)
        was_rd_r <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_rst_pulse: assert property (
    wr_c && paddr == 8'h04 && pwdata[7:0] == 8'h55 |-> ##[1:2] chip_rst_req)
    else $error("reset pattern gave no pulse");
  chk_rst_single: assert property (
    chip_rst_req |=> !chip_rst_req) else $error("reset pulse too long");
  chk_erase_page: assert property (
    flash_erase_req |-> flash_addr[5:0] == 6'h00)
    else $error("erase not page aligned");
  chk_op_stall: assert property (
    flash_rd_req || flash_erase_req |-> ##[0:1] cpu_stall)
    else $error("operation without stall");
  // a page write's first program pulse trails the stall by two cycles
  chk_stall_cause: assert property (
    $rose(cpu_stall) |-> (flash_rd_req || flash_erase_req)
      or ##2 flash_prog_req)
    else $error("stall without operation");
  chk_prog_order: assert property (
    flash_prog_req |-> flash_addr[5:0] == prog_cnt_r[5:0])
    else $error("program word out of order");
  chk_prog_count: assert property (
    $fell(cpu_stall) && prog_cnt_r != 7'h0 |-> prog_cnt_r == 7'h40)
    else $error("page program count wrong");
  chk_read_time: assert property (
    $fell(cpu_stall) && was_rd_r |-> len_r >= READ_CYC - 1
      && len_r <= READ_CYC + 1) else $error("read length wrong");
  chk_ew_time: assert property (
    $fell(cpu_stall) && !was_rd_r |-> len_r >= EW_CYC - 2
      && len_r <= EW_CYC + 1) else $error("erase or write length wrong");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  cover property (flash_erase_req);
  cover property (flash_prog_req && flash_addr[5:0] == 6'h3F);
  cover property (flash_rd_req);
  cover property (chip_rst_req);
endmodule

bind iafc_ctrl iafc_ctrl_assertions #(
  .EW_CYC(EW_CYC), .READ_CYC(READ_CYC)) u_chk (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .cpu_stall(cpu_stall), .chip_rst_req(chip_rst_req),
  .flash_rd_req(flash_rd_req), .flash_erase_req(flash_erase_req),
  .flash_prog_req(flash_prog_req), .flash_addr(flash_addr));

// *** iafc_ctrl_tb.sv ***
module iafc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        cpu_stall, chip_rst_req, flash_rd_req, flash_erase_req;
  logic        flash_prog_req, quiet;
  logic [7:0]  paddr, page;
  logic [31:0] pwdata, prdata, rd_r;
  logic [13:0] flash_addr;
  logic [15:0] flash_wdata, flash_rdata;
  logic [15:0] words [6];
  logic [3:0]  lat, cmd;
  logic [2:0]  md;
  logic [64:0] exp_q [$];
  logic [64:0] mon_e;
  int          n_fail, checked;
  // short counts keep the run brief; unlock window fits seven transfers
  iafc_ctrl #(.EW_CYC(200), .UNLOCK_CYC(32)) dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
    .chip_rst_req(chip_rst_req), .flash_rd_req(flash_rd_req),
    .flash_erase_req(flash_erase_req), .flash_prog_req(flash_prog_req),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata));
  iafc_flash_model u_flash (
    .core_clk(core_clk), .rd_req(flash_rd_req), .erase_req(flash_erase_req),
    .prog_req(flash_prog_req), .addr(flash_addr), .wdata(flash_wdata),
    .lat(lat), .rdata(flash_rdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && !quiet) begin
      mon_e = exp_q.pop_front();
      check({pslverr, prdata & mon_e[63:32]}, {mon_e[64], mon_e[31:0]});
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // ready and read data are taken at the same rising edge
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      conclude();
    end
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic err = 1'b0);
    exp_q.push_back({err, err ? 32'h0 : 32'hFFFFFFFF, x});
    apb(1'b0, a, 8'h00);
  endtask
  // waits for a self-clearing bit; reads here are not scored
  task automatic poll(input logic [7:0] a, input int b);
    int k;
    quiet = 1'b1;
    k = 0;
    do begin
      apb(1'b0, a, 8'h00);
      k++;
    end while (rd_r[b] !== 1'b0 && k < 200);
    quiet = 1'b0;
    if (k >= 200) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic fread(input logic [13:0] a, input logic [15:0] x);
    lat <= 4'($urandom_range(8, 0));
    wr(8'h0C, a[7:0]);
    wr(8'h10, {2'b00, a[13:8]});
    wr(8'h00, 8'hB3);
    poll(8'h00, 0);
    rd(8'h14, {24'h0, x[7:0]});
    rd(8'h18, {24'h0, x[15:8]});
  endtask
  task automatic unlock(input logic [7:0] last_key);
    wr(8'h00, 8'h68);
    rd(8'h00, 32'h68);
    wr(8'h1C, 8'h00);
    wr(8'h24, 8'h0D);
    wr(8'h2C, 8'hC3);
    wr(8'h20, 8'h04);
    wr(8'h28, 8'h09);
    wr(8'h30, last_key);
    poll(8'h00, 3);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {rst, quiet} = 2'b10;
    {psel, penable, pwrite, paddr, pwdata, lat} = '0;
    n_fail = 0;
    checked = 0;
    void'($urandom(32'hF4F3));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a <= 48; a += 4)
      rd(8'(a), 32'h0);
    rd(8'h34, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    wr(8'h00, 8'h80);
    rd(8'h00, 32'h0);
    wr(8'h00, 8'h14);
    poll(8'h00, 2);
    rd(8'h00, 32'h10);
    wr(8'h14, 8'hAA);
    wr(8'h18, 8'hBB);
    rd(8'h0C, 32'h0);
    $display("test reset and refusals done");
    unlock(8'h41);
    rd(8'h00, 32'h60);
    unlock(8'h40);
    rd(8'h00, 32'hE0);
    $display("test unlock done");
    page = 8'($urandom_range(255, 0));
    wr(8'h0C, {page[1:0], 6'h2A});
    wr(8'h10, {2'b00, page[7:2]});
    wr(8'h00, 8'h94);
    rd(8'h00, 32'h94);
    poll(8'h00, 2);
    fread({page, 6'h05}, 16'h0000);
    $display("test erase done");
    wr(8'h08, 8'h01);
    rd(8'h08, 32'h1);
    poll(8'h08, 0);
    wr(8'h00, 8'h80);
    wr(8'h0C, {page[1:0], 6'h3C});
    for (int i = 0; i < 6; i++) begin
      words[i] = 16'($urandom());
      wr(8'h14, words[i][7:0]);
      if (i == 0)
        rd(8'h0C, {24'h0, page[1:0], 6'h3C});
      wr(8'h18, words[i][15:8]);
    end
    rd(8'h0C, {24'h0, page[1:0], 6'h3F});
    wr(8'h00, 8'h84);
    poll(8'h00, 2);
    fread({page, 6'h3D}, words[1]);
    fread({page, 6'h3F}, words[5]);
    fread({page, 6'h00}, 16'h0000);
    $display("test page write done");
    wr(8'h0C, {page[1:0], 6'h3F});
    wr(8'h00, 8'hB1);
    poll(8'h00, 0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    wr(8'h00, 8'hB7);
    rd(8'h00, 32'hB2);
    for (int i = 0; i < 8; i++) begin
      cmd = i[0] ? 4'b0011 : 4'b0100;
      // reserved codes only: 2, 4, 5, 7
      md = 3'(2 + i / 2 * 2 - (i >= 4));
      wr(8'h00, {1'b1, md, cmd});
      poll(8'h00, i[0] ? 0 : 2);
      rd(8'h00, {24'h0, 1'b1, md, cmd & 4'hA});
    end
    $display("test read and modes done");
    wr(8'h04, 8'h55);
    rd(8'h04, 32'h55);
    wr(8'h04, 8'h3C);
    rd(8'h04, 32'h3C);
    wr(8'h00, 8'h00);
    rd(8'h00, 32'h0);
    wr(8'h0C, {page[1:0], 6'h00});
    wr(8'h00, 8'h14);
    poll(8'h00, 2);
    fread({page, 6'h3D}, words[1]);
    $display("test reset pattern and disable done");
    conclude();
  end
endmodule

// *** iafc_flash_model.sv ***
module iafc_flash_model (
  input  wire logic        core_clk,
  input  wire logic        rd_req,
  input  wire logic        erase_req,
  input  wire logic        prog_req,
  input  wire logic [13:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [3:0]  lat,
  output logic      [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [13:0]];
  logic [15:0] word_r;
  logic [3:0]  cnt_r;
  initial begin
    rdata = 16'hFFFF;
    word_r = 16'h0000;
    cnt_r = 4'h0;
  end
  // untouched cells hold a nonzero pattern so an erase is visible
  always @(posedge core_clk) begin
    if (erase_req)
      for (int i = 0; i < 64; i++)
        mem[{addr[13:6], i[5:0]}] = 16'h0000;
    if (prog_req)
      mem[addr] = wdata;
    if (rd_req) begin
      word_r = mem.exists(addr) ? mem[addr] : 16'hA5A5;
      cnt_r = lat;
    end else if (cnt_r != 4'h0)
      cnt_r = cnt_r - 4'h1;
    // slow answer: lines toggle until the word settles
    rdata <= (cnt_r == 4'h0) ? word_r : ~rdata;
  end
endmodule

// *** iafc_map.svh ***
`ifndef IAFC_MAP_SVH
`define IAFC_MAP_SVH

// register word offsets on the apb bus (byte addresses)
`define IAFC_OFF_CTRL      8'h00
`define IAFC_OFF_RSTPAT    8'h04
`define IAFC_OFF_BUFCLR    8'h08
`define IAFC_OFF_ADDR_LO   8'h0C
`define IAFC_OFF_ADDR_HI   8'h10
`define IAFC_OFF_D0_LO     8'h14
`define IAFC_OFF_D0_HI     8'h18
`define IAFC_OFF_K1_LO     8'h1C
`define IAFC_OFF_K1_HI     8'h20
`define IAFC_OFF_K2_LO     8'h24
`define IAFC_OFF_K2_HI     8'h28
`define IAFC_OFF_K3_LO     8'h2C
`define IAFC_OFF_K3_HI     8'h30

// flash_op_control and buffer clear field positions
`define IAFC_BIT_EWEN      7
`define IAFC_MODE_MSB      6
`define IAFC_MODE_LSB      4
`define IAFC_BIT_TRIG      3
`define IAFC_BIT_WI        2
`define IAFC_BIT_RDE       1
`define IAFC_BIT_RI        0
`define IAFC_BIT_CLR       0

// mode codes
`define IAFC_MODE_WRITE    3'h0
`define IAFC_MODE_ERASE    3'h1
`define IAFC_MODE_READ     3'h3
`define IAFC_MODE_UNLOCK   3'h6

// unlock key bytes
`define IAFC_KEY1_LO       8'h00
`define IAFC_KEY2_LO       8'h0D
`define IAFC_KEY3_LO       8'hC3
`define IAFC_KEY1_HI       8'h04
`define IAFC_KEY2_HI       8'h09
`define IAFC_KEY3_HI       8'h40

`define IAFC_RST_PATTERN   8'h55
`define IAFC_RESET_BYTE    8'h00

// timing
`define IAFC_CLK_PERIOD_NS 100
`define IAFC_EW_TIME_NS    2200000
`define IAFC_EW_CYC        (`IAFC_EW_TIME_NS / `IAFC_CLK_PERIOD_NS)
`define IAFC_READ_INSTR    3
`define IAFC_CLK_PER_INSTR 4
`define IAFC_READ_CYC      (`IAFC_READ_INSTR * `IAFC_CLK_PER_INSTR)
`define IAFC_UNLOCK_CYC    256

`endif

// *** iafc_pkg.sv ***
package iafc_pkg;

  typedef enum logic [2:0] {
    IAFC_IDLE,
    IAFC_UNLOCK,
    IAFC_PROG,
    IAFC_BCLR,
    IAFC_WAIT,
    IAFC_READ
  } iafc_fsm_t;

  typedef struct packed {
    iafc_fsm_t   st;
    logic        after_prog;
    logic        ew_en;
    logic [2:0]  mode;
    logic        trig;
    logic        wi;
    logic        rde;
    logic        ri;
    logic        clr;
    logic [7:0]  rst_pat;
    logic [13:0] addr;
    logic [7:0]  d0l;
    logic [7:0]  d0h;
    logic [7:0]  k1l;
    logic [7:0]  k1h;
    logic [7:0]  k2l;
    logic [7:0]  k2h;
    logic [7:0]  k3l;
    logic [7:0]  k3h;
    logic [6:0]  idx;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        stall;
    logic        chip_rst;
    logic        read_initiate;
    logic        fera;
    logic        fprog;
    logic [13:0] faddr;
    logic [15:0] fwdata;
  } iafc_state_t;

endpackage

// *** iafc_timer.sv ***
module iafc_timer
  import iafc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] load_val,
  output logic              busy,
  output logic              expire
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } iafc_tmr_state_t;

  iafc_tmr_state_t s_r;
  iafc_tmr_state_t s_nxt;

  if (W < 2) begin : g_chk
    $error("iafc_timer: width too small");
  end

  // expire is a one-cycle pulse on the last count
  always_comb begin
    s_nxt = s_r;
    if (start) begin
      s_nxt.cnt = load_val;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
    busy   = (s_r.cnt != '0);
    expire = (s_r.cnt == W'(1)) && !start;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// *** iafc_wbuf.sv ***
module iafc_wbuf
  import iafc_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int WIDTH = 16
) (
  input  wire logic                     core_clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } iafc_wbuf_state_t;

  iafc_wbuf_state_t s_r;
  iafc_wbuf_state_t s_nxt;

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("iafc_wbuf: bad geometry");
  end

  // array carries no reset; contents are defined by the clear walk
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.mem[raddr];
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
    rdata = s_r.rdata;
  end

  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

endmodule
